// [hdl/pllcfg_top.v]
// Purpose: staged/active configuration of pll power, detector, pump, vco divider and distribution source
// Assumes: axi4-lite slave on clk_in; all settings apply together on an update write
// Notes: current step code shares the antibacklash register bits [4:2]
//   update register reads back zero; only the exact command value fires the copy
//   status word at its own index shows the live power, divider, bypass, source and calibration bits for software
//
// Overview of operation
// R1: software routes internal vco through divider
// R2: calibration bit plus update starts calibration
// R3: software clears calibration before recalibrating
// R4: divider field selects ratio two to six
// R5: bypass bit skips divider when one
// R6: source bit picks internal vco when one
// R7: power code 00 on, 01 down
// R8: external vco below limit: pll on, bypass
// R9: polarity bit zero positive, one negative
// R10: staged values apply on update write 0x01
// R11: two-bit field sets antibacklash width
// R12: pump mode: hiz, normal, up, down
// R13: pump current in eight equal steps
// R14: reset: pll off, divide four, external source
// R15: divider code 010 means divide four
// R16: software keeps reference and divider running
// R17: update applies all staged values at once
`timescale 1ns/1ps
`default_nettype none
`include "pllcfg_map.vh"
module pllcfg_top #(
	parameter ADDR_W = 12
) (
	input wire clk_in,
	input wire srst_in,
	input wire [ADDR_W-1:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [ADDR_W-1:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output reg pll_power_down_out,
	output reg [2:0] charge_pump_mode_out,
	output reg [3:0] charge_pump_current_out,
	output reg phase_frequency_detector_negative_out,
	output reg [1:0] antibacklash_width_out,
	output reg [2:0] vco_divide_ratio_out,
	output reg vco_divider_bypass_out,
	output reg internal_vco_select_out,
	output reg vco_cal_start_out,
	output reg vco_cal_reset_out,
	output reg update_pulse_out
);

	// staged copies written by software
	reg [7:0] stg_pump_r;
	reg [7:0] stg_abl_r;
	reg [7:0] stg_cal_r;
	reg [7:0] stg_div_r;
	reg [7:0] stg_src_r;
	// active copies steering the clock path
	reg [7:0] act_pump_r;
	reg [7:0] act_abl_r;
	reg [7:0] act_cal_r;
	reg [7:0] act_div_r;
	reg [7:0] act_src_r;
	// write channel capture
	reg aw_held_r;
	reg w_held_r;
	reg [ADDR_W-1:0] aw_addr_r;
	reg [7:0] w_byte_r;
	reg w_lane0_r;
	wire wr_go;
	wire wr_update;
	wire [9:0] wr_idx;
	wire [9:0] rd_idx;
	reg [7:0] rd_val;
	reg rd_hit;

	// the read address is decoded live, so araddr must hold until arready
	// word index from byte address; unaligned low bits are ignored
	function [9:0] word_idx;
		input [ADDR_W-1:0] addr;
		begin
			word_idx = addr[11:2];
		end
	endfunction

	// index match against a printed register offset
	function idx_is;
		input [9:0] idx;
		input [11:0] reg_idx;
		begin
			idx_is = (idx == reg_idx[9:0]);
		end
	endfunction

	// divider code to ratio; out-of-range codes clamp to divide-by-six
	function [2:0] div_ratio;
		input [2:0] code;
		begin
			if (code > `PLLCFG_DIV_CODE_MAX) begin
				div_ratio = `PLLCFG_DIV_RATIO_MAX;
			end else begin
				div_ratio = code + `PLLCFG_DIV_RATIO_BASE;
			end
		end
	endfunction

	// writable register decode; status word is read-only
	function wr_known;
		input [9:0] idx;
		begin
			wr_known = idx_is(idx, `PLLCFG_IDX_PUMP_CTRL) || idx_is(idx, `PLLCFG_IDX_ANTIBACKLASH) ||
				idx_is(idx, `PLLCFG_IDX_VCO_CAL) || idx_is(idx, `PLLCFG_IDX_VCO_DIV) ||
				idx_is(idx, `PLLCFG_IDX_DIST_SRC) || idx_is(idx, `PLLCFG_IDX_UPDATE);
		end
	endfunction

	// address and data may come in either order; accept once both are held
	assign s_axi_awready_out = !aw_held_r && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held_r && !s_axi_bvalid_out;
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid_out;
	assign wr_idx = word_idx(aw_addr_r);
	// R10: only the exact command value triggers the transfer
	assign wr_update = wr_go && w_lane0_r && idx_is(wr_idx, `PLLCFG_IDX_UPDATE) && (w_byte_r == `PLLCFG_UPDATE_CMD);

	// write address/data holding and response
	always @(posedge clk_in) begin
		if (srst_in) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= {ADDR_W{1'b0}};
			w_byte_r <= 8'h00;
			w_lane0_r <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `PLLCFG_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_in;
			end
			// without lane 0 the write still answers okay but stages nothing
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_r <= 1'b1;
				w_byte_r <= s_axi_wdata_in[7:0];
				w_lane0_r <= s_axi_wstrb_in[0];
			end
			// bvalid blocks both channels, so a second write cannot overtake the response
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_known(wr_idx) ? `PLLCFG_RESP_OKAY : `PLLCFG_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// staged registers; writes here change nothing in the clock path yet
	// a write to the update index stages nothing, the copy below handles it
	always @(posedge clk_in) begin
		if (srst_in) begin
			// R14: staged defaults match the active defaults
			stg_pump_r <= `PLLCFG_RST_PUMP_CTRL;
			stg_abl_r <= `PLLCFG_RST_ANTIBACKLASH;
			stg_cal_r <= `PLLCFG_RST_VCO_CAL;
			stg_div_r <= `PLLCFG_RST_VCO_DIV;
			stg_src_r <= `PLLCFG_RST_DIST_SRC;
		end else if (wr_go && w_lane0_r) begin
			if (idx_is(wr_idx, `PLLCFG_IDX_PUMP_CTRL)) begin
				stg_pump_r <= w_byte_r;
			end
			if (idx_is(wr_idx, `PLLCFG_IDX_ANTIBACKLASH)) begin
				stg_abl_r <= w_byte_r;
			end
			if (idx_is(wr_idx, `PLLCFG_IDX_VCO_CAL)) begin
				stg_cal_r <= w_byte_r;
			end
			if (idx_is(wr_idx, `PLLCFG_IDX_VCO_DIV)) begin
				stg_div_r <= w_byte_r;
			end
			if (idx_is(wr_idx, `PLLCFG_IDX_DIST_SRC)) begin
				stg_src_r <= w_byte_r;
			end
		end
	end

	// R17: one edge copies every staged value, so no partial setting is ever live
	always @(posedge clk_in) begin
		if (srst_in) begin
			// R14: pll off, divide-by-four, divider in use, external input
			act_pump_r <= `PLLCFG_RST_PUMP_CTRL;
			act_abl_r <= `PLLCFG_RST_ANTIBACKLASH;
			act_cal_r <= `PLLCFG_RST_VCO_CAL;
			act_div_r <= `PLLCFG_RST_VCO_DIV;
			act_src_r <= `PLLCFG_RST_DIST_SRC;
		end else if (wr_update) begin
			// the update word itself is never staged; it only fires this copy
			act_pump_r <= stg_pump_r;
			act_abl_r <= stg_abl_r;
			act_cal_r <= stg_cal_r;
			act_div_r <= stg_div_r;
			act_src_r <= stg_src_r;
		end
	end

	// decoded outputs from the active copies, registered; calibration and update pulses come from the update write
	always @(posedge clk_in) begin
		if (srst_in) begin
			// reset state leaves the pll down and the divider at four
			pll_power_down_out <= 1'b1;
			charge_pump_mode_out <= `PLLCFG_PUMP_HIZ;
			charge_pump_current_out <= 4'h0;
			phase_frequency_detector_negative_out <= 1'b0;
			antibacklash_width_out <= 2'h0;
			vco_divide_ratio_out <= `PLLCFG_RST_RATIO;
			vco_divider_bypass_out <= 1'b0;
			internal_vco_select_out <= 1'b0;
			vco_cal_start_out <= 1'b0;
			vco_cal_reset_out <= 1'b0;
			update_pulse_out <= 1'b0;
		end else begin
			// R7: only code 00 runs the pll; other codes keep it down
			pll_power_down_out <= (act_pump_r[`PLLCFG_PWR_MSB:`PLLCFG_PWR_LSB] != `PLLCFG_PWR_NORMAL);
			// R12: mode field passes as coded
			charge_pump_mode_out <= act_pump_r[`PLLCFG_PUMP_MODE_MSB:`PLLCFG_PUMP_MODE_LSB];
			// R13: eight equal current steps, code 0 is the lowest
			charge_pump_current_out <= {1'b0, act_abl_r[`PLLCFG_CUR_MSB:`PLLCFG_CUR_LSB]};
			// R9: polarity bit
			phase_frequency_detector_negative_out <= act_pump_r[`PLLCFG_POLARITY_BIT];
			// R11: antibacklash width code
			antibacklash_width_out <= act_abl_r[`PLLCFG_ABL_MSB:`PLLCFG_ABL_LSB];
			// R4: divide ratio; R15: code 010 gives four
			vco_divide_ratio_out <= div_ratio(act_div_r[`PLLCFG_DIV_MSB:`PLLCFG_DIV_LSB]);
			// R5: bypass bit
			vco_divider_bypass_out <= act_src_r[`PLLCFG_BYPASS_BIT];
			// R6: source bit
			internal_vco_select_out <= act_src_r[`PLLCFG_SRC_BIT];
			// R2: a rising calibration bit at update starts calibration
			// needs the active bit clear, so a repeated set without a clear is ignored
			vco_cal_start_out <= wr_update && stg_cal_r[`PLLCFG_CAL_BIT] && !act_cal_r[`PLLCFG_CAL_BIT];
			// R3: a cleared bit at update resets calibration
			vco_cal_reset_out <= wr_update && !stg_cal_r[`PLLCFG_CAL_BIT];
			// update pulse marks the edge at which the new settings go live
			update_pulse_out <= wr_update;
		end
	end

	// read decode; status word shows the live power, divider, bypass, source and calibration bits
	assign rd_idx = word_idx(s_axi_araddr_in);
	always @* begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		if (idx_is(rd_idx, `PLLCFG_IDX_PUMP_CTRL)) begin
			rd_val = stg_pump_r;
		end else if (idx_is(rd_idx, `PLLCFG_IDX_ANTIBACKLASH)) begin
			rd_val = stg_abl_r;
		end else if (idx_is(rd_idx, `PLLCFG_IDX_VCO_CAL)) begin
			rd_val = stg_cal_r;
		end else if (idx_is(rd_idx, `PLLCFG_IDX_VCO_DIV)) begin
			rd_val = stg_div_r;
		end else if (idx_is(rd_idx, `PLLCFG_IDX_DIST_SRC)) begin
			rd_val = stg_src_r;
		end else if (idx_is(rd_idx, `PLLCFG_IDX_UPDATE)) begin
			rd_val = 8'h00; // update reads back zero, it is self-clearing
		end else if (idx_is(rd_idx, `PLLCFG_IDX_ACTIVE_STATUS)) begin
			rd_val = {act_cal_r[`PLLCFG_CAL_BIT], act_src_r[`PLLCFG_SRC_BIT:`PLLCFG_BYPASS_BIT],
				act_div_r[`PLLCFG_DIV_MSB:`PLLCFG_DIV_LSB], act_pump_r[`PLLCFG_PWR_MSB:`PLLCFG_PWR_LSB]};
		end else begin
			// unmapped reads answer slverr with zero data
			rd_hit = 1'b0;
		end
	end

	// one read at a time: arready drops while the data waits
	assign s_axi_arready_out = !s_axi_rvalid_out;
	// read data waits in rdata until rready, nothing new is taken meanwhile
	always @(posedge clk_in) begin
		if (srst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `PLLCFG_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= {24'h000000, rd_val};
			s_axi_rresp_out <= rd_hit ? `PLLCFG_RESP_OKAY : `PLLCFG_RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [hdl/pllcfg_map.vh]
// Purpose: register map and field layout for the pll clock path configuration block
// Assumes: byte offsets as printed; 32-bit axi4-lite words, each register one aligned word
// Notes: definitions only
`ifndef PLLCFG_MAP_VH
`define PLLCFG_MAP_VH
// register indices, byte address is four times the index
`define PLLCFG_IDX_PUMP_CTRL 12'h010
`define PLLCFG_IDX_ANTIBACKLASH 12'h017
`define PLLCFG_IDX_VCO_CAL 12'h018
`define PLLCFG_IDX_VCO_DIV 12'h1e0
`define PLLCFG_IDX_DIST_SRC 12'h1e1
`define PLLCFG_IDX_UPDATE 12'h232
`define PLLCFG_IDX_ACTIVE_STATUS 12'h300
// reset values of staged and active registers
`define PLLCFG_RST_PUMP_CTRL 8'h01
`define PLLCFG_RST_ANTIBACKLASH 8'h00
`define PLLCFG_RST_VCO_CAL 8'h00
`define PLLCFG_RST_VCO_DIV 8'h02
`define PLLCFG_RST_DIST_SRC 8'h00
// update command value
`define PLLCFG_UPDATE_CMD 8'h01
// field positions
`define PLLCFG_PWR_MSB 1
`define PLLCFG_PWR_LSB 0
`define PLLCFG_PUMP_MODE_MSB 6
`define PLLCFG_PUMP_MODE_LSB 4
`define PLLCFG_POLARITY_BIT 7
`define PLLCFG_ABL_MSB 1
`define PLLCFG_ABL_LSB 0
`define PLLCFG_CAL_BIT 0
`define PLLCFG_DIV_MSB 2
`define PLLCFG_DIV_LSB 0
`define PLLCFG_BYPASS_BIT 0
`define PLLCFG_SRC_BIT 1
// pump current step code sits in the antibacklash register above the width field
`define PLLCFG_CUR_MSB 4
`define PLLCFG_CUR_LSB 2
// pll power codes
`define PLLCFG_PWR_NORMAL 2'h0
`define PLLCFG_PWR_ASYNC_DOWN 2'h1
// charge pump modes
`define PLLCFG_PUMP_HIZ 3'h0
`define PLLCFG_PUMP_UP 3'h1
`define PLLCFG_PUMP_DOWN 3'h2
`define PLLCFG_PUMP_NORMAL 3'h3
// vco divider code to ratio offset
`define PLLCFG_DIV_CODE_MAX 3'h4
`define PLLCFG_DIV_RATIO_BASE 3'h2
`define PLLCFG_DIV_RATIO_MAX 3'h6
`define PLLCFG_RST_RATIO 3'h4
// axi responses
`define PLLCFG_RESP_OKAY 2'h0
`define PLLCFG_RESP_SLVERR 2'h2
`endif

// [bench/pllcfg_monitor.sv]
// Purpose: port assertions for the pll clock path configuration block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by the bind after the module
`timescale 1ns/1ps
`default_nettype none
module pllcfg_monitor (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic pll_power_down_out,
	input wire logic [2:0] charge_pump_mode_out,
	input wire logic [3:0] charge_pump_current_out,
	input wire logic phase_frequency_detector_negative_out,
	input wire logic [1:0] antibacklash_width_out,
	input wire logic [2:0] vco_divide_ratio_out,
	input wire logic vco_divider_bypass_out,
	input wire logic internal_vco_select_out,
	input wire logic vco_cal_start_out,
	input wire logic vco_cal_reset_out,
	input wire logic update_pulse_out
);
	// all active settings in one word, so any change outside an update is caught
	wire logic [15:0] cfg_w = {pll_power_down_out, charge_pump_mode_out, charge_pump_current_out,
		phase_frequency_detector_negative_out, antibacklash_width_out, vco_divide_ratio_out,
		vco_divider_bypass_out, internal_vco_select_out};
	default clocking mon_cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	a_update_one_cycle: assert property (update_pulse_out |=> !update_pulse_out)
		else $error("update pulse wider than one cycle");
	a_update_after_write: assert property (update_pulse_out |-> s_axi_bvalid_out)
		else $error("update pulse without a write response");
	a_cfg_held_between: assert property (!$past(update_pulse_out) && !$past(srst_in) |-> $stable(cfg_w))
		else $error("active setting moved outside an update");
	a_ratio_in_range: assert property (vco_divide_ratio_out inside {[3'h2:3'h6]})
		else $error("divide ratio outside two to six");
	a_current_eight_steps: assert property (!charge_pump_current_out[3])
		else $error("pump current step beyond seven");
	a_cal_start_update: assert property (vco_cal_start_out |-> update_pulse_out && !vco_cal_reset_out)
		else $error("calibration start outside an update");
	a_cal_reset_update: assert property (vco_cal_reset_out |-> update_pulse_out)
		else $error("calibration reset outside an update");
	a_reset_defaults: assert property ($past(srst_in) |-> pll_power_down_out && vco_divide_ratio_out == 3'h4
		&& !vco_divider_bypass_out && !internal_vco_select_out) else $error("wrong settings after reset");
	a_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data not one cycle after address");
	a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
		&& $stable(s_axi_bresp_out)) else $error("write response dropped early");
endmodule
bind pllcfg_top pllcfg_monitor i_mon (.*);
`default_nettype wire

// [bench/pllcfg_src_model.sv]
// Purpose: external clock source feeding the distribution path
// Assumes: source runs free, unrelated to the register clock
// Notes: divided output is counted by the bench to show that it keeps running
`timescale 1ns/1ps
`default_nettype none
module pllcfg_src_model (
	input wire logic [2:0] ratio_in,
	input wire logic bypass_in,
	output logic src_clk_out,
	output logic dist_clk_out
);
	logic [2:0] cnt_r = 3'h0;
	initial src_clk_out = 1'h0;
	initial dist_clk_out = 1'h0;
	always #1.7 src_clk_out = ~src_clk_out;
	// divider keeps toggling; bypass toggles the output on every rising source edge, so it runs at half the source rate
	// an unknown ratio before reset only counts on, so the counter never locks at x
	always @(posedge src_clk_out) begin
		if (bypass_in || cnt_r + 3'h1 >= ratio_in) begin
			cnt_r <= 3'h0;
			dist_clk_out <= ~dist_clk_out;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
endmodule
`default_nettype wire

// [bench/tb_pll_clock_path_config.sv]
// Purpose: self-checking bench for the pll clock path configuration block
// Assumes: axi4-lite master, one register per word at four times the index
// Notes: random settings from a fixed seed, first eight passes walk every power, pump mode, current and divider code
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_path_config;
	logic clk_in = 1'h0;
	logic srst_in = 1'h1;
	logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'h1;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
	wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out, antibacklash_width_out;
	wire logic [31:0] s_axi_rdata_out;
	wire logic [2:0] charge_pump_mode_out, vco_divide_ratio_out;
	wire logic [3:0] charge_pump_current_out;
	wire logic pll_power_down_out, phase_frequency_detector_negative_out, vco_divider_bypass_out;
	wire logic internal_vco_select_out, vco_cal_start_out, vco_cal_reset_out, update_pulse_out;
	wire logic [15:0] cfg_w = {pll_power_down_out, charge_pump_mode_out, charge_pump_current_out,
		phase_frequency_detector_negative_out, antibacklash_width_out, vco_divide_ratio_out,
		vco_divider_bypass_out, internal_vco_select_out};
	int error_cnt = 0, checks = 0, cyc = 0, n_upd = 0, n_st = 0, n_rs = 0, n_dist = 0;
	wire logic dist_clk;
	int i, enu, ens, enr;
	logic [7:0] p, a, d, s;
	logic [15:0] old;
	pllcfg_top i_dut (.*);
	pllcfg_src_model i_src (.ratio_in(vco_divide_ratio_out), .bypass_in(vco_divider_bypass_out),
		.src_clk_out(), .dist_clk_out(dist_clk));
	always #2 clk_in = ~clk_in;
	// the far side's divided clock must keep running
	always @(posedge dist_clk) n_dist <= n_dist + 1;
	// pulse tallies, the pulses stand one cycle so each is counted once
	always @(posedge clk_in) begin
		n_upd <= n_upd + update_pulse_out;
		n_st <= n_st + vco_cal_start_out;
		n_rs <= n_rs + vco_cal_reset_out;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	// expected active word for staged pump, antibacklash, divider and source bytes
	function automatic logic [15:0] exp_cfg(input logic [7:0] p, a, d, s);
		logic [2:0] r;
		r = (d[2:0] > 3'h4) ? 3'h6 : d[2:0] + 3'h2;
		return {p[1:0] != 2'h0, p[6:4], 1'h0, a[4:2], p[7], a[1:0], r, s[0], s[1]};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// both channels offered together, each dropped once taken, bready held until bvalid
	task wr(input logic [11:0] ad, input logic [7:0] dt, input logic [1:0] er);
		logic done;
		done = 1'h0;
		@(posedge clk_in);
		s_axi_awaddr_in <= ad;
		s_axi_wdata_in <= {24'h0, dt};
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		while (!done) begin
			@(posedge clk_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
			if (s_axi_bvalid_out === 1'h1) begin
				done = 1'h1;
				s_axi_bready_in <= 1'h0;
				chk({30'h0, s_axi_bresp_out}, {30'h0, er});
			end
		end
	endtask
	task rd(input logic [11:0] ad, input logic [7:0] ed, input logic [1:0] er);
		logic done;
		done = 1'h0;
		@(posedge clk_in);
		s_axi_araddr_in <= ad;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		while (!done) begin
			@(posedge clk_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
			if (s_axi_rvalid_out === 1'h1) begin
				done = 1'h1;
				s_axi_rready_in <= 1'h0;
				chk(s_axi_rdata_out, {24'h0, ed});
				chk({30'h0, s_axi_rresp_out}, {30'h0, er});
			end
		end
	endtask
	// outputs land one edge after the response, pulse tallies on that same edge
	task settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task tally_and_finish;
		$display("mismatches %0d of %0d checks", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(28));
		repeat (6) @(posedge clk_in);
		srst_in <= 1'h0;
		#1;
		old = exp_cfg(8'h01, 8'h00, 8'h02, 8'h00);
		chk(cfg_w, old);
		rd(12'hc00, 8'h09, 2'h0);
		rd(12'h040, 8'h01, 2'h0);
		rd(12'h780, 8'h02, 2'h0);
		rd(12'h004, 8'h00, 2'h2);
		wr(12'h004, 8'hff, 2'h2);
		// a write without lane 0 answers okay and leaves the staged byte alone
		s_axi_wstrb_in <= 4'h0;
		wr(12'h040, 8'h55, 2'h0);
		s_axi_wstrb_in <= 4'h1;
		rd(12'h040, 8'h01, 2'h0);
		{enu, ens, enr} = 0;
		for (i = 0; i < 16; i++) begin
			{p, a, d, s} = $urandom;
			if (i < 8) begin
				p[6:4] = i[2:0];
				p[1:0] = i[1:0];
				a[4:2] = i[2:0];
				d[2:0] = i[2:0];
			end
			wr(12'h040, p, 2'h0);
			wr(12'h05c, a, 2'h0);
			wr(12'h780, d, 2'h0);
			wr(12'h784, s, 2'h0);
			rd(12'h784, s, 2'h0);
			wr(12'h8c8, 8'h02, 2'h0);
			settle;
			chk(cfg_w, old);
			chk(n_upd, enu);
			wr(12'h8c8, 8'h01, 2'h0);
			settle;
			old = exp_cfg(p, a, d, s);
			enu++;
			enr++;
			chk(cfg_w, old);
			chk(n_upd, enu);
			chk(n_rs, enr);
			rd(12'hc00, {1'h0, s[1:0], d[2:0], p[1:0]}, 2'h0);
		end
		// set, set again, clear, set: only a fresh set after a clear starts
		for (i = 0; i < 4; i++) begin
			wr(12'h060, {7'h0, i != 2}, 2'h0);
			wr(12'h8c8, 8'h01, 2'h0);
			settle;
			ens += (i == 0 || i == 3);
			enr += (i == 2);
			chk(n_st, ens);
			chk(n_rs, enr);
		end
		@(posedge clk_in);
		srst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'h0;
		#1;
		chk(cfg_w, exp_cfg(8'h01, 8'h00, 8'h02, 8'h00));
		rd(12'h060, 8'h00, 2'h0);
		chk(n_dist > 0, 32'h1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
